// [hdl/pls_pkg.sv]
package pls_pkg;
  // Register-file and peripheral addresses.
  localparam logic [7:0] ADDR_MODE_SEL  = 8'h21;
  localparam logic [7:0] ADDR_REF_SEL   = 8'h31;
  localparam logic [7:0] ADDR_DIVISOR   = 8'h41;
  localparam logic [7:0] ADDR_UNLOCK    = 8'h22;
  // Mode codes.
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_SWALLOW_HI = 4'h2;
  localparam logic [3:0] MODE_SWALLOW_LO = 4'h3;
  localparam logic [3:0] MODE_DIRECT     = 4'h1;
  // Reference codes and reset values.
  localparam logic [3:0]  REF_DISABLE     = 4'hF;
  localparam logic [3:0]  RESET_REF_SEL   = 4'hF;
  localparam logic [3:0]  RESET_MODE_SEL  = 4'h0;
  localparam logic [15:0] RESET_DIVISOR   = 16'h0000;
  // Crystal 4.5 MHz, reference period counts in ticks of clk (50 MHz).
  localparam int CLK_HZ = 50000000;
  // Reference period in clk cycles for each code, given by frequency in hertz.
  function automatic logic [15:0] ref_period(input logic [3:0] code);
    int hz;
    begin
      unique case (code)
        4'h0: hz = 1250;
        4'h1: hz = 2500;
        4'h2: hz = 5000;
        4'h3: hz = 10000;
        4'h4: hz = 6250;
        4'h5: hz = 12500;
        4'h6: hz = 25000;
        4'h7: hz = 50000;
        4'h8: hz = 3000;
        4'hC: hz = 1000;
        4'hD: hz = 9000;
        4'hE: hz = 100000;
        default: hz = 50000000;
      endcase
      ref_period = 16'(CLK_HZ / hz);
    end
  endfunction : ref_period
endpackage : pls_pkg

// [hdl/pls_sync.sv]
`timescale 1ns/1ps
// Three-stage input synchroniser; the output changes once stages two and three agree.
module pls_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Data.
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule : pls_sync

// [hdl/pls_synth.sv]
`timescale 1ns/1ps
// How it works
// - Comparator requests lead/lag; none when disabled.
// - Error pins: low, high, or float.
// - A lead or lag request at the reference tick means out of lock.
// - Out of lock sets unlock flag.
// - Unlock flag updated once per reference period.
// - Window_read_instruction read of unlock register clears it.
// - Unlock register ignores writes.
// - Chip-enable low stops the synthesizer.
// - Reference code 1111B disables synthesizer.
// - Disabled: inputs low, counters stop, pins float.
// - Mode 0000B only gates oscillator inputs.
// - Mode 0000B normally drives error pins low.
// - Chip-enable reset keeps select registers.
// - Power-on comes up disabled.
// - Power-on loads reference select 1111B.
// - Direct division uses low-band input.
// - Swallow lower uses low, upper high.
module pls_synth #(
  parameter int DIV_W = 16
) (
  // Clock and power-on reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Chip-enable pin.
  input  wire logic             chipEnable,
  // Register access.
  input  wire logic             regWrite,
  input  wire logic             windowReadInstruction,
  input  wire logic [7:0]       regAddr,
  input  wire logic [DIV_W-1:0] regWdata,
  output logic      [DIV_W-1:0] regRdata,
  // Oscillator inputs.
  input  wire logic             lowBandOscInput,
  input  wire logic             highBandOscInput,
  // Error-out pins.
  output logic                  errorOutHiPin,
  output logic                  errorOutHiPinOe,
  output logic                  errorOutLoPin,
  output logic                  errorOutLoPinOe,
  // Status.
  output logic                  synthEnabled,
  output logic                  unlockFlag
);
  logic [3:0]       synthDivisionModeSelect;
  logic [3:0]       synthReferenceSelect;
  logic [DIV_W-1:0] synthDivisorValue;
  logic             ceSync;
  logic             lowSync;
  logic             highSync;
  logic             oscPrev;
  logic [DIV_W-1:0] divCount;
  logic [15:0]      refCount;
  logic             refTick;
  logic             divTick;
  logic             leadRequest;
  logic             lagRequest;
  logic             leadWin;
  logic             lagWin;
  logic             runSynth;
  logic             oscSel;
  logic             oscGated;
  logic             unlockRead;

  pls_sync ceSyncInst (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (chipEnable),
    .dout  (ceSync)
  );
  pls_sync lowSyncInst (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (lowBandOscInput),
    .dout  (lowSync)
  );
  pls_sync highSyncInst (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (highBandOscInput),
    .dout  (highSync)
  );

  // Disabled by chip-enable low or the disabling reference code.
  assign runSynth = ceSync && (synthReferenceSelect != pls_pkg::REF_DISABLE);

  // Input selection per division mode; other codes pull both inputs low.
  always_comb begin
    oscSel = 1'b0;
    unique case (synthDivisionModeSelect)
      pls_pkg::MODE_DIRECT:     oscSel = lowSync;
      pls_pkg::MODE_SWALLOW_LO: oscSel = lowSync;
      pls_pkg::MODE_SWALLOW_HI: oscSel = highSync;
      default:                  oscSel = 1'b0;
    endcase
  end
  assign oscGated = oscSel && runSynth;

  // Registers survive chip-enable; only power-on reset initialises them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synthReferenceSelect    <= pls_pkg::RESET_REF_SEL;
      synthDivisionModeSelect <= pls_pkg::RESET_MODE_SEL;
      synthDivisorValue       <= pls_pkg::RESET_DIVISOR;
    end else if (regWrite) begin
      if (regAddr == pls_pkg::ADDR_REF_SEL) begin
        synthReferenceSelect <= regWdata[3:0];
      end
      if (regAddr == pls_pkg::ADDR_MODE_SEL) begin
        synthDivisionModeSelect <= regWdata[3:0];
      end
      if (regAddr == pls_pkg::ADDR_DIVISOR) begin
        synthDivisorValue <= regWdata;
      end
    end
  end

  // Programmable counter: one divided pulse every divisor input edges.
  assign divTick = runSynth && oscGated && !oscPrev &&
                   (divCount + DIV_W'(1) >= synthDivisorValue);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev  <= 1'b0;
      divCount <= '0;
    end else if (!runSynth) begin
      oscPrev  <= 1'b0;
      divCount <= '0;
    end else begin
      oscPrev <= oscGated;
      if (oscGated && !oscPrev) begin
        divCount <= divTick ? '0 : divCount + DIV_W'(1);
      end
    end
  end

  // Reference generator.
  assign refTick = runSynth && (refCount == 16'h0000);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refCount <= 16'h0000;
    end else if (!runSynth) begin
      refCount <= 16'h0000;
    end else if (refCount == 16'h0000) begin
      refCount <= pls_pkg::ref_period(synthReferenceSelect) - 16'h0001;
    end else begin
      refCount <= refCount - 16'h0001;
    end
  end

  // Comparator: lead when reference edge comes first, lag when divided edge first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      leadWin <= 1'b0;
      lagWin  <= 1'b0;
    end else if (!runSynth) begin
      leadWin <= 1'b0;
      lagWin  <= 1'b0;
    end else if (refTick && divTick) begin
      leadWin <= 1'b0;
      lagWin  <= 1'b0;
    end else if (refTick) begin
      leadWin <= !lagWin;
      lagWin  <= 1'b0;
    end else if (divTick) begin
      lagWin  <= !leadWin;
      leadWin <= 1'b0;
    end
  end
  assign leadRequest = leadWin;
  assign lagRequest  = lagWin;

  // Charge pump: lead drives low, lag drives high, else float.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errorOutHiPin   <= 1'b0;
      errorOutLoPin   <= 1'b0;
      errorOutHiPinOe <= 1'b0;
      errorOutLoPinOe <= 1'b0;
    end else begin
      errorOutHiPin   <= lagRequest && runSynth;
      errorOutLoPin   <= lagRequest && runSynth;
      errorOutHiPinOe <= (leadRequest || lagRequest) && runSynth;
      errorOutLoPinOe <= (leadRequest || lagRequest) && runSynth;
    end
  end

  // Unlock flag: sampled once per reference period, cleared by a window_read_instruction of the unlock register.
  assign unlockRead = windowReadInstruction && (regAddr == pls_pkg::ADDR_UNLOCK);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlockFlag <= 1'b0;
    end else if (refTick && (leadRequest || lagRequest)) begin
      unlockFlag <= 1'b1;
    end else if (unlockRead) begin
      unlockFlag <= 1'b0;
    end
  end

  // Read data path; writes never reach the unlock flag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (windowReadInstruction) begin
      unique case (regAddr)
        pls_pkg::ADDR_MODE_SEL: regRdata <= DIV_W'(synthDivisionModeSelect);
        pls_pkg::ADDR_REF_SEL:  regRdata <= DIV_W'(synthReferenceSelect);
        pls_pkg::ADDR_DIVISOR:  regRdata <= synthDivisorValue;
        pls_pkg::ADDR_UNLOCK:   regRdata <= DIV_W'(unlockFlag);
        default:                regRdata <= '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synthEnabled <= 1'b0;
    end else begin
      synthEnabled <= runSynth;
    end
  end

  sequence peekSeq;
    unlockRead && !(refTick && (leadRequest || lagRequest));
  endsequence

  unlock_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    peekSeq |=> !unlockFlag)
    else $error("unlock flag not cleared by window_read_instruction");
  unlock_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (refTick && (leadRequest || lagRequest)) |=> unlockFlag)
    else $error("unlock flag not set");
  unlock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!refTick && !unlockFlag) |=> !unlockFlag)
    else $error("unlock flag set off the reference tick");
  pins_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    !runSynth |=> !errorOutHiPinOe && !errorOutLoPinOe)
    else $error("error pins driven while disabled");
  no_request_a: assert property (@(posedge clk) disable iff (!rst_n)
    !runSynth |=> !leadRequest && !lagRequest)
    else $error("request while disabled");
  pin_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    (runSynth && leadRequest) |=> errorOutLoPinOe && !errorOutLoPin)
    else $error("lead did not drive low");
  ref_disable_a: assert property (@(posedge clk) disable iff (!rst_n)
    (synthReferenceSelect == pls_pkg::REF_DISABLE) |=> !synthEnabled)
    else $error("disable code did not disable");
  mode_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (synthDivisionModeSelect == pls_pkg::MODE_OFF) |-> !oscGated)
    else $error("oscillator passed in mode off");
  ce_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ceSync |=> !synthEnabled ##0 refCount == 16'h0000)
    else $error("chip enable low did not stop");

  // Request levels as seen by the pump, including the case of no request.
  sequence lagSeq;
    runSynth && lagRequest;
  endsequence

  sequence leadSeq;
    runSynth && leadRequest;
  endsequence

  sequence idleSeq;
    runSynth && !leadRequest && !lagRequest;
  endsequence

  // Pump polarity on both pins, for each request and for none.
  pin_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    lagSeq |=> errorOutHiPinOe && errorOutHiPin)
    else $error("lag did not drive high");

  pin_lo_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    lagSeq |=> errorOutLoPinOe && errorOutLoPin)
    else $error("lag did not drive second pin high");

  pin_hi_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    leadSeq |=> errorOutHiPinOe && !errorOutHiPin)
    else $error("lead did not drive first pin low");

  pin_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    idleSeq |=> !errorOutHiPinOe && !errorOutLoPinOe)
    else $error("pins driven with no request");

  pins_equal_a: assert property (@(posedge clk) disable iff (!rst_n)
    (errorOutHiPin == errorOutLoPin) && (errorOutHiPinOe == errorOutLoPinOe))
    else $error("error pins disagree");

  request_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(leadRequest && lagRequest))
    else $error("lead and lag requested together");

  // A set in the same cycle as a window_read_instruction must win over the clear.
  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (unlockRead && refTick && (leadRequest || lagRequest)) |=> unlockFlag)
    else $error("window_read_instruction clear beat the unlock set");

  read_unlock_a: assert property (@(posedge clk) disable iff (!rst_n)
    unlockRead |=> regRdata == DIV_W'($past(unlockFlag)))
    else $error("window_read_instruction returned wrong unlock value");

  unlock_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (regWrite && (regAddr == pls_pkg::ADDR_UNLOCK) && !unlockFlag && !refTick) |=> !unlockFlag)
    else $error("write reached the unlock flag");

  // Oscillator input choice per division mode.
  direct_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (runSynth && (synthDivisionModeSelect == pls_pkg::MODE_DIRECT)) |-> oscGated == lowSync)
    else $error("direct mode did not use low band");

  swallow_lo_a: assert property (@(posedge clk) disable iff (!rst_n)
    (runSynth && (synthDivisionModeSelect == pls_pkg::MODE_SWALLOW_LO)) |-> oscGated == lowSync)
    else $error("lower swallow did not use low band");

  swallow_hi_a: assert property (@(posedge clk) disable iff (!rst_n)
    (runSynth && (synthDivisionModeSelect == pls_pkg::MODE_SWALLOW_HI)) |-> oscGated == highSync)
    else $error("upper swallow did not use high band");

  // Disabled blocks hold still; mode off starves the counter only.
  counter_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    !runSynth |=> divCount == '0)
    else $error("counter ran while disabled");

  ref_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    !runSynth |-> !refTick)
    else $error("reference ticked while disabled");

  mode_off_div_a: assert property (@(posedge clk) disable iff (!rst_n)
    (synthDivisionModeSelect == pls_pkg::MODE_OFF) |-> !divTick)
    else $error("divided tick in mode off");

  ref_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    refTick |=> !runSynth ||
      (refCount == pls_pkg::ref_period($past(synthReferenceSelect)) - 16'h0001))
    else $error("reference period wrong");

  // Select registers change only by a write, whatever chip-enable does.
  select_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !regWrite |=> $stable(synthReferenceSelect) && $stable(synthDivisionModeSelect))
    else $error("select register changed without a write");

  enable_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    runSynth |=> synthEnabled)
    else $error("enable did not follow run state");
endmodule : pls_synth

// [sim/pls_vco_model.sv]
`timescale 1ns/1ps
// Free-running low-band and high-band oscillators that stand in for the external VCO pair.
// Their phases are offset so that neither is aligned with the system clock.
module pls_vco_model #(
  parameter int LO_HALF_NS = 100,
  parameter int HI_HALF_NS = 1000
) (
  // Control.
  input  wire logic run,
  // Oscillator outputs.
  output logic      lowBandOsc,
  output logic      highBandOsc
);
  initial begin
    lowBandOsc = 1'b0;
    #3;
    forever begin
      #(LO_HALF_NS);
      lowBandOsc = run ? ~lowBandOsc : 1'b0;
    end
  end

  initial begin
    highBandOsc = 1'b0;
    #7;
    forever begin
      #(HI_HALF_NS);
      highBandOsc = run ? ~highBandOsc : 1'b0;
    end
  end
endmodule : pls_vco_model

// [sim/pls_synth_tb.sv]
`timescale 1ns/1ps
module pls_synth_tb;
  logic        clk;
  logic        rst_n;
  logic        chipEnable;
  logic        regWrite;
  logic        windowReadInstruction;
  logic [7:0]  regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic        lowOsc;
  logic        highOsc;
  logic        vcoRun;
  logic        errorOutHiPin;
  logic        errorOutHiPinOe;
  logic        errorOutLoPin;
  logic        errorOutLoPinOe;
  logic        synthEnabled;
  logic        unlockFlag;
  logic [15:0] d;
  int          errorCnt = 0;
  int          nTests = 0;
  int          lo;
  int          hi;
  int          t;
  logic        seen;
  logic [3:0]  modes [3] = '{pls_pkg::MODE_DIRECT, pls_pkg::MODE_SWALLOW_LO,
                             pls_pkg::MODE_SWALLOW_HI};
  localparam int REF_CYC = pls_pkg::CLK_HZ / 100000;

  pls_synth i_dut (.clk(clk), .rst_n(rst_n), .chipEnable(chipEnable), .regWrite(regWrite),
    .windowReadInstruction(windowReadInstruction), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .lowBandOscInput(lowOsc), .highBandOscInput(highOsc),
    .errorOutHiPin(errorOutHiPin), .errorOutHiPinOe(errorOutHiPinOe),
    .errorOutLoPin(errorOutLoPin), .errorOutLoPinOe(errorOutLoPinOe),
    .synthEnabled(synthEnabled), .unlockFlag(unlockFlag));

  pls_vco_model i_vco (.run(vcoRun), .lowBandOsc(lowOsc), .highBandOsc(highOsc));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge clk);
    regAddr = a;
    regWdata = v;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(negedge clk);
    regAddr = a;
    windowReadInstruction = 1'b1;
    @(negedge clk);
    windowReadInstruction = 1'b0;
    v = regRdata;
  endtask : rd

  // Counts cycles with the pump driving high and driving low.
  task automatic pump(input int n, output int nLo, output int nHi);
    logic same;
    nLo = 0;
    nHi = 0;
    same = 1'b1;
    repeat (n) begin
      @(negedge clk);
      if (errorOutHiPinOe === 1'b1 && errorOutHiPin === 1'b1) nHi++;
      if (errorOutHiPinOe === 1'b1 && errorOutHiPin === 1'b0) nLo++;
      if (errorOutLoPin !== errorOutHiPin || errorOutLoPinOe !== errorOutHiPinOe) same = 1'b0;
    end
    chk({15'h0, same}, 16'h0001, "error pins differ");
  endtask : pump

  task final_report;
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge clk);
    errorCnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    chipEnable = 1'b1;
    regWrite = 1'b0;
    windowReadInstruction = 1'b0;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    vcoRun = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk({15'h0, synthEnabled}, 16'h0000, "enabled after reset");
    chk({15'h0, errorOutHiPinOe}, 16'h0000, "pump driven after reset");
    rd(pls_pkg::ADDR_REF_SEL, d);
    chk(d, 16'h000F, "reference select reset");
    wr(pls_pkg::ADDR_UNLOCK, 16'h0001);
    rd(pls_pkg::ADDR_UNLOCK, d);
    chk(d, 16'h0000, "unlock register took a write");
    repeat (REF_CYC + 100) @(negedge clk);
    chk({15'h0, unlockFlag}, 16'h0000, "unlock set while disabled");
    $display("test reset done");
    wr(pls_pkg::ADDR_DIVISOR, 16'h0014);
    wr(pls_pkg::ADDR_REF_SEL, 16'h000E);
    rd(pls_pkg::ADDR_DIVISOR, d);
    chk(d, 16'h0014, "divisor readback");
    for (int i = 0; i < 3; i++) begin
      wr(pls_pkg::ADDR_MODE_SEL, {12'h000, modes[i]});
      repeat (2000) @(negedge clk);
      chk({15'h0, synthEnabled}, 16'h0001, "not enabled");
      pump(3000, lo, hi);
      chk({15'h0, (i < 2) ? (hi > lo) : (lo > hi)}, 16'h0001, "pump level");
    end
    $display("test modes done");
    wr(pls_pkg::ADDR_MODE_SEL, {12'h000, pls_pkg::MODE_DIRECT});
    repeat (REF_CYC + 100) @(negedge clk);
    chk({15'h0, unlockFlag}, 16'h0001, "unlock not set");
    rd(pls_pkg::ADDR_UNLOCK, d);
    chk(d, 16'h0001, "unlock read value");
    chk({15'h0, unlockFlag}, 16'h0000, "unlock not cleared by read");
    t = 0;
    while (unlockFlag !== 1'b1 && t < REF_CYC + 20) begin
      @(negedge clk);
      t++;
    end
    chk({15'h0, t < REF_CYC + 20}, 16'h0001, "unlock not set again");
    rd(pls_pkg::ADDR_UNLOCK, d);
    seen = 1'b0;
    repeat (REF_CYC - 50) begin
      @(negedge clk);
      if (unlockFlag === 1'b1) seen = 1'b1;
    end
    chk({15'h0, seen}, 16'h0000, "unlock set twice in a period");
    $display("test unlock done");
    wr(pls_pkg::ADDR_MODE_SEL, {12'h000, pls_pkg::MODE_OFF});
    repeat (2000) @(negedge clk);
    pump(3000, lo, hi);
    chk({15'h0, hi == 0 && lo > 0}, 16'h0001, "mode off pump level");
    chk({15'h0, synthEnabled}, 16'h0001, "mode off disabled the loop");
    $display("test mode off done");
    chipEnable = 1'b0;
    repeat (10) @(negedge clk);
    chk({15'h0, synthEnabled}, 16'h0000, "running with chip-enable low");
    pump(1000, lo, hi);
    chk({15'h0, hi == 0 && lo == 0}, 16'h0001, "pump driven with chip-enable low");
    chipEnable = 1'b1;
    repeat (10) @(negedge clk);
    rd(pls_pkg::ADDR_REF_SEL, d);
    chk(d, 16'h000E, "reference select lost");
    rd(pls_pkg::ADDR_MODE_SEL, d);
    chk(d, 16'h0000, "mode select lost");
    chk({15'h0, synthEnabled}, 16'h0001, "not resumed");
    $display("test chip-enable done");
    wr(pls_pkg::ADDR_REF_SEL, 16'h000F);
    repeat (10) @(negedge clk);
    chk({15'h0, synthEnabled}, 16'h0000, "code F left loop running");
    pump(1000, lo, hi);
    chk({15'h0, hi == 0 && lo == 0}, 16'h0001, "pump driven with code F");
    $display("test reference disable done");
    final_report();
  end
endmodule : pls_synth_tb
